//--- rtl/charger_pkg.sv
// Purpose: Shared constants and types for the charger register bank
// Assumes: 10 MHz system clock
// Notes: Register layouts travel as packed structs
package charger_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int SAFETY_TIME_S = 32;
   localparam int SAFETY_CYCLES = SAFETY_TIME_S * CLK_HZ;
   localparam int BLINK_MS = 128;
   localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
   localparam logic [6:0] SLAVE_ADDR = 7'h6a;
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_CONFIG = 8'h01;
   localparam logic [7:0] OFF_FLOAT = 8'h02;
   localparam logic [7:0] OFF_IDENT = 8'h03;
   localparam logic [7:0] OFF_CURRENT = 8'h04;
   localparam logic [7:0] OFF_SPECIAL = 8'h05;
   localparam logic [7:0] OFF_SAFETY = 8'h06;
   localparam logic [7:0] OFF_MONITOR = 8'h10;
   localparam logic [1:0] CHG_IN_PROGRESS = 2'h1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic IND_EN_RST = 1'b1;

   typedef struct packed {
      logic host_role_pin_level;
      logic indicator_low_en;
      logic [1:0] charge_state;
      logic step_up_active;
      logic [2:0] fault_code;
   } status_s;
   typedef struct packed {
      logic [1:0] input_current_cap;
      logic [1:0] weak_battery_level;
      logic cutoff_enable;
      logic charger_off;
      logic input_high_impedance;
      logic step_up_select;
   } charge_config_s;
   typedef struct packed {
      logic [5:0] float_voltage_code;
      logic host_pin_polarity;
      logic host_pin_enable;
   } float_voltage_s;
   typedef struct packed {
      logic [2:0] maker_code;
      logic [2:0] part_code;
      logic [1:0] silicon_version;
   } identity_s;
   typedef struct packed {
      logic soft_reset;
      logic [2:0] charge_current_code;
      logic reserved_one;
      logic [2:0] cutoff_current_code;
   } charge_current_s;
   typedef struct packed {
      logic unused;
      logic regulator_off;
      logic fixed_current_sel;
      logic [1:0] live_bits;
      logic [2:0] input_hold_code;
   } special_charger_s;
   typedef struct packed {
      logic unused;
      logic [2:0] current_limit;
      logic [3:0] voltage_limit;
   } safety_limits_s;
   typedef struct packed {
      charge_config_s cfg;
      float_voltage_s flt;
      charge_current_s cur;
      special_charger_s spc;
      safety_limits_s saf;
   } charge_ctrl_s;
   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [7:0] data;
   } link_req_s;

   localparam charge_config_s CONFIG_RST = 8'h70;
   localparam float_voltage_s FLOAT_RST = 8'h0a;
   localparam charge_current_s CURRENT_RST = 8'h89;
   localparam special_charger_s SPECIAL_RST = 8'h24;
   localparam safety_limits_s SAFETY_RST = 8'h40;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_DEV = 4'h1,
      ST_DEV_ACK = 4'h3,
      ST_REG = 4'h2,
      ST_REG_ACK = 4'h6,
      ST_WDATA = 4'h7,
      ST_WACK = 4'h5,
      ST_RDATA = 4'h4,
      ST_RACK = 4'hc
   } i2c_state_e;
endpackage

//--- rtl/charger_register_bank.sv
// Purpose: Serial-bus register bank of a single-cell charger with step-up mode
// Assumes: Bus pins oversampled on link_clk; registers live on clk
// Notes: No clock stretching, SCL period must exceed a few clk cycles
`timescale 1ns/1ps
// Overview of operation
// - Writing 1 to status bit 7 restarts the 32 s safety timer.
// - Status bit 7 reads the synchronised host role pin level.
// - Indicator pin low while charging only if enabled; faults pulse it when it is not held low by charging.
// - Status bit 3 reads 1 in step-up mode, read-only.
// - Status bits 2:0 report the live fault code, read-only.
// - Status register resets with bit 6 set and bit 3 clear.
// - Config bits 7:6 hold the input current cap, reset 01.
// - Config bits 5:4 select weak battery level 3.4 to 3.7 V.
// - Config bit 3 enables cutoff termination.
// - Config bit 2 turns charger off; safety timer keeps running.
// - Config resets to 0x70; bits 1 and 0 are high-z and step-up.
// - Float bits 7:2 hold the float voltage code, reset 000010.
// - Float register resets 0x0a; bit 1 polarity, bit 0 host pin enable.
// - Identity register read-only: maker, part, version fields.
// - Current bit 7 write 1 restores defaults except safety; reads 1.
// - Current bits 6:4 charge current, reset 000, used when fixed bit 0.
// - Current bits 2:0 cutoff current, reset 001.
// - Current register resets 0x89; bit 3 reads 1.
// - Slave answers 7-bit address 1101010 only.
module charger_register_bank
   import charger_pkg::*;
#(
   parameter int SAFETY_TIMER_CYCLES = SAFETY_CYCLES,
   parameter int FAULT_BLINK_CYCLES = BLINK_CYCLES,
   parameter logic [2:0] MAKER_CODE = 3'h2, // Arbitrary value
   parameter logic [2:0] PART_CODE = 3'h3, // Arbitrary value
   parameter logic [1:0] SILICON_VERSION = 2'h1 // Arbitrary value
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic host_role_pin_level,
   input wire logic [1:0] charge_state,
   input wire logic step_up_active,
   input wire logic [2:0] fault_code,
   input wire logic fault_active,
   input wire logic boost_fault,
   input wire logic [1:0] special_live,
   input wire logic [7:0] monitor_bits,
   output charge_ctrl_s ctrl,
   output logic charge_current_in_use,
   output logic safety_timer_kick,
   output logic safety_timer_expired,
   output logic indicator_out,
   output logic indicator_oe
);
   localparam int TW = $clog2(SAFETY_TIMER_CYCLES + 1);
   localparam int BW = $clog2(FAULT_BLINK_CYCLES + 1);

   if (SAFETY_TIMER_CYCLES < 2 || FAULT_BLINK_CYCLES < 2) begin : g_chk
      $error("Timer counts must be at least 2");
   end

   // ---- Link domain: pin synchronisers and edge detection
   logic [2:0] scl_q_r;
   logic [2:0] sda_q_r;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   // First stage feeds only the second; edges use stages two and three
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q_r <= 3'h7;
         sda_q_r <= 3'h7;
      end else begin
         scl_q_r <= {scl_q_r[1:0], scl_in};
         sda_q_r <= {sda_q_r[1:0], sda_in};
      end
   end

   assign scl_rise = scl_q_r[1] & ~scl_q_r[2];
   assign scl_fall = ~scl_q_r[1] & scl_q_r[2];
   assign bus_start = scl_q_r[1] & scl_q_r[2] & ~sda_q_r[1] & sda_q_r[2];
   assign bus_stop = scl_q_r[1] & scl_q_r[2] & sda_q_r[1] & ~sda_q_r[2];

   // ---- Link domain: protocol engine
   i2c_state_e state_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] ptr_r;
   logic rw_r;
   logic sda_oe_r;
   link_req_s req_r;
   logic req_tgl_r;
   logic [7:0] rd_byte_r;
   logic byte_done;

   assign byte_done = scl_fall && (bit_cnt_r == BITS_PER_BYTE);

   // Byte framing, acknowledge, pointer and request issue
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         sda_oe_r <= 1'b0;
         req_r <= '0;
         req_tgl_r <= 1'b0;
      end else if (bus_start) begin
         state_r <= ST_DEV; // Repeated start keeps the pointer
         bit_cnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end else if (bus_stop) begin
         state_r <= ST_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         case (state_r)
            ST_DEV, ST_REG, ST_WDATA: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_q_r[1]};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               if (byte_done) begin
                  bit_cnt_r <= 4'h0;
                  if (state_r == ST_DEV) begin
                     if (shift_r[7:1] == SLAVE_ADDR) begin
                        sda_oe_r <= 1'b1;
                        rw_r <= shift_r[0];
                        state_r <= ST_DEV_ACK;
                        if (shift_r[0]) begin
                           req_r <= '{write: 1'b0, addr: ptr_r, data: 8'h00};
                           req_tgl_r <= ~req_tgl_r;
                           ptr_r <= ptr_r + 8'h01;
                        end
                     end else begin
                        state_r <= ST_IDLE; // Not ours: stay off the bus
                     end
                  end else if (state_r == ST_REG) begin
                     ptr_r <= shift_r;
                     sda_oe_r <= 1'b1;
                     state_r <= ST_REG_ACK;
                  end else begin
                     req_r <= '{write: 1'b1, addr: ptr_r, data: shift_r};
                     req_tgl_r <= ~req_tgl_r;
                     ptr_r <= ptr_r + 8'h01;
                     sda_oe_r <= 1'b1;
                     state_r <= ST_WACK;
                  end
               end
            end
            ST_DEV_ACK: begin
               if (scl_fall) begin
                  if (rw_r) begin
                     shift_r <= rd_byte_r;
                     sda_oe_r <= ~rd_byte_r[7];
                     bit_cnt_r <= 4'h1;
                     state_r <= ST_RDATA;
                  end else begin
                     sda_oe_r <= 1'b0;
                     state_r <= ST_REG;
                  end
               end
            end
            ST_REG_ACK, ST_WACK: begin
               if (scl_fall) begin
                  sda_oe_r <= 1'b0;
                  bit_cnt_r <= 4'h0;
                  state_r <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (byte_done) begin
                  sda_oe_r <= 1'b0;
                  bit_cnt_r <= 4'h0;
                  state_r <= ST_RACK;
               end else if (scl_fall) begin
                  shift_r <= {shift_r[6:0], 1'b0};
                  sda_oe_r <= ~shift_r[6];
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (!sda_q_r[1]) begin
                     req_r <= '{write: 1'b0, addr: ptr_r, data: 8'h00};
                     req_tgl_r <= ~req_tgl_r;
                     ptr_r <= ptr_r + 8'h01;
                     state_r <= ST_DEV_ACK; // Next byte loads at the fall
                  end else begin
                     state_r <= ST_IDLE; // Master NACK ends the read
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_r;

   // ---- Crossing: request toggle to clk, answer toggle back
   logic [1:0] req_sync_r;
   logic req_seen_r;
   logic ack_tgl_r;
   logic [7:0] rdata_r;
   logic [1:0] ack_sync_r;
   logic ack_seen_r;
   logic req_edge, wr_fire;

   // Request toggle synchroniser in the register domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_sync_r <= 2'h0;
         req_seen_r <= 1'b0;
      end else begin
         req_sync_r <= {req_sync_r[0], req_tgl_r};
         req_seen_r <= req_sync_r[1];
      end
   end

   assign req_edge = req_sync_r[1] ^ req_seen_r;
   assign wr_fire = req_edge & req_r.write; // Request fields stable while toggle travels

   // Answer toggle synchroniser and read byte capture in the link domain
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_sync_r <= 2'h0;
         ack_seen_r <= 1'b0;
         rd_byte_r <= 8'h00;
      end else begin
         ack_sync_r <= {ack_sync_r[0], ack_tgl_r};
         ack_seen_r <= ack_sync_r[1];
         if (ack_sync_r[1] ^ ack_seen_r) begin
            rd_byte_r <= rdata_r;
         end
      end
   end

   // ---- Register domain
   logic [1:0] role_sync_r;
   logic ind_en_r;
   charge_config_s cfg_r;
   float_voltage_s flt_r;
   charge_current_s cur_r;
   special_charger_s spc_r;
   safety_limits_s saf_r;
   status_s stat_word;
   identity_s ident_word;
   charge_current_s cur_word;
   special_charger_s spc_word;
   safety_limits_s saf_word;
   logic [7:0] rd_word;
   logic soft_rst;

   // Host role pin synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         role_sync_r <= 2'h0;
      end else begin
         role_sync_r <= {role_sync_r[0], host_role_pin_level};
      end
   end

   assign soft_rst = wr_fire && req_r.addr == OFF_CURRENT && req_r.data[7];

   // Writable registers; unmapped offsets fall through
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ind_en_r <= IND_EN_RST;
         cfg_r <= CONFIG_RST;
         flt_r <= FLOAT_RST;
         cur_r <= CURRENT_RST;
         spc_r <= SPECIAL_RST;
         saf_r <= SAFETY_RST;
      end else begin
         if (soft_rst) begin
            ind_en_r <= IND_EN_RST;
            cfg_r <= CONFIG_RST;
            flt_r <= FLOAT_RST;
            cur_r <= CURRENT_RST;
            spc_r <= SPECIAL_RST;
         end else if (wr_fire) begin
            case (req_r.addr)
               OFF_STATUS: ind_en_r <= req_r.data[6];
               OFF_CONFIG: cfg_r <= req_r.data;
               OFF_FLOAT: flt_r <= req_r.data;
               OFF_CURRENT: cur_r <= req_r.data;
               OFF_SPECIAL: spc_r <= req_r.data;
               OFF_SAFETY: saf_r <= req_r.data;
               default: ;
            endcase
         end
         if (boost_fault) begin
            cfg_r.step_up_select <= 1'b0; // Fault wins over a same-cycle write
         end
      end
   end

   // Read views with fixed and live bits
   always_comb begin
      stat_word.host_role_pin_level = role_sync_r[1];
      stat_word.indicator_low_en = ind_en_r;
      stat_word.charge_state = charge_state;
      stat_word.step_up_active = step_up_active;
      stat_word.fault_code = fault_code;
      ident_word = '{maker_code: MAKER_CODE, part_code: PART_CODE,
                     silicon_version: SILICON_VERSION};
      cur_word = cur_r;
      cur_word.soft_reset = 1'b1;
      cur_word.reserved_one = 1'b1;
      spc_word = spc_r;
      spc_word.unused = 1'b0;
      spc_word.live_bits = special_live;
      saf_word = saf_r;
      saf_word.unused = 1'b0;
   end

   // Read multiplexer; unmapped reads return zero
   always_comb begin
      case (req_r.addr)
         OFF_STATUS: rd_word = stat_word;
         OFF_CONFIG: rd_word = cfg_r;
         OFF_FLOAT: rd_word = flt_r;
         OFF_IDENT: rd_word = ident_word;
         OFF_CURRENT: rd_word = cur_word;
         OFF_SPECIAL: rd_word = spc_word;
         OFF_SAFETY: rd_word = saf_word;
         OFF_MONITOR: rd_word = monitor_bits;
         default: rd_word = 8'h00;
      endcase
   end

   // Answer every request: capture read data, toggle back
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
         ack_tgl_r <= 1'b0;
      end else if (req_edge) begin
         rdata_r <= rd_word;
         ack_tgl_r <= ~ack_tgl_r;
      end
   end

   // Safety timer: kick restarts it, charger-off does not pause it
   logic [TW-1:0] tmr_cnt_r;
   logic kick_r;
   logic kick_now;

   assign kick_now = wr_fire && req_r.addr == OFF_STATUS && req_r.data[7];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_cnt_r <= '0;
         kick_r <= 1'b0;
         safety_timer_expired <= 1'b0;
      end else begin
         kick_r <= kick_now;
         if (kick_now) begin
            tmr_cnt_r <= '0;
            safety_timer_expired <= 1'b0;
         end else if (tmr_cnt_r == TW'(SAFETY_TIMER_CYCLES - 1)) begin
            safety_timer_expired <= 1'b1;
         end else begin
            tmr_cnt_r <= tmr_cnt_r + 1'b1;
         end
      end
   end

   // Indicator: low while charging when enabled, blinks on faults
   logic [BW-1:0] blink_cnt_r;
   logic blink_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blink_cnt_r <= '0;
         blink_r <= 1'b0;
         indicator_oe <= 1'b0;
      end else begin
         if (!fault_active) begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
         end else if (blink_cnt_r == BW'(FAULT_BLINK_CYCLES - 1)) begin
            blink_cnt_r <= '0;
            blink_r <= ~blink_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
         end
         indicator_oe <= (ind_en_r && charge_state == CHG_IN_PROGRESS) ||
                         (fault_active && blink_r);
      end
   end

   assign indicator_out = 1'b0;
   assign safety_timer_kick = kick_r;
   assign charge_current_in_use = ~spc_r.fixed_current_sel;
   assign ctrl = '{cfg: cfg_r, flt: flt_r, cur: cur_word, spc: spc_word, saf: saf_word};

   // ---- Checks
   property p_kick;
      @(posedge clk) disable iff (!rst_n)
      kick_now |=> safety_timer_kick && tmr_cnt_r == '0 && !safety_timer_expired;
   endproperty
   a_kick: assert property (p_kick) else $error("Kick did not restart timer");

   property p_role;
      @(posedge clk) disable iff (!rst_n)
      host_role_pin_level [*3] |-> stat_word.host_role_pin_level;
   endproperty
   a_role: assert property (p_role) else $error("Role pin level not reported");

   property p_ind;
      @(posedge clk) disable iff (!rst_n)
      (!ind_en_r && !fault_active) |=> !indicator_oe;
   endproperty
   a_ind: assert property (p_ind) else $error("Indicator driven while disabled");

   property p_boost;
      @(posedge clk) disable iff (!rst_n)
      req_edge && req_r.addr == OFF_STATUS && step_up_active |=> rdata_r[3];
   endproperty
   a_boost: assert property (p_boost) else $error("Step-up bit not read");

   property p_soft;
      @(posedge clk) disable iff (!rst_n)
      soft_rst |=> cfg_r == CONFIG_RST && flt_r == FLOAT_RST && saf_r == $past(saf_r);
   endproperty
   a_soft: assert property (p_soft) else $error("Soft reset wrong");

   property p_fixed;
      @(posedge clk) disable iff (!rst_n)
      req_edge && req_r.addr == OFF_CURRENT |=> rdata_r[7] && rdata_r[3];
   endproperty
   a_fixed: assert property (p_fixed) else $error("Fixed current bits not one");

   property p_unmapped;
      @(posedge clk) disable iff (!rst_n)
      wr_fire && req_r.addr > OFF_SAFETY && !boost_fault |=>
         $stable(cfg_r) && $stable(flt_r) && $stable(cur_r) && $stable(saf_r);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("Unmapped write changed state");

   property p_timer_off;
      @(posedge clk) disable iff (!rst_n)
      cfg_r.charger_off && !kick_now && !safety_timer_expired &&
         tmr_cnt_r != TW'(SAFETY_TIMER_CYCLES - 1) |=> tmr_cnt_r == $past(tmr_cnt_r) + 1'b1;
   endproperty
   a_timer_off: assert property (p_timer_off) else $error("Timer paused while off");

   property p_addr;
      @(posedge link_clk) disable iff (!rst_n)
      state_r == ST_DEV && byte_done && shift_r[7:1] != SLAVE_ADDR && !bus_start |=> !sda_oe [*2];
   endproperty
   a_addr: assert property (p_addr) else $error("Foreign address acknowledged");

   c_write: cover property (@(posedge clk) disable iff (!rst_n) wr_fire && req_r.addr == OFF_CONFIG);
   c_read: cover property (@(posedge clk) disable iff (!rst_n) req_edge && !req_r.write);
   c_soft: cover property (@(posedge clk) disable iff (!rst_n) soft_rst);
   c_kick: cover property (@(posedge clk) disable iff (!rst_n) kick_now);
endmodule

//--- verification/i2c_host_model.sv
// Purpose: Serial bus master that reaches the charger register bank
// Assumes: Open-drain data line with a pull-up, resolved by the bench
// Notes: One quarter bit lasts Q system clocks; no clock stretching
`timescale 1ns/1ps
module i2c_host_model #(
   parameter int Q = 8
) (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_pull
);
   localparam logic [6:0] SLAVE_ADDR_W = 7'h6a;
   int nacks = 0;
   // Bus idle: both lines released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Quarter-bit waits and one clock pulse that samples the data line
   task automatic tick();
      repeat (Q) @(posedge clk);
   endtask
   task automatic pulse(output logic s);
      scl <= 1'b1;
      tick();
      s = sda_in;
      tick();
      scl <= 1'b0;
      tick();
   endtask
   // Start or repeated start: data falls while the clock is high
   task automatic start();
      sda_pull <= 1'b0;
      tick();
      scl <= 1'b1;
      tick();
      sda_pull <= 1'b1;
      tick();
      scl <= 1'b0;
      tick();
   endtask
   // Stop: data rises while the clock is high
   task automatic stop();
      sda_pull <= 1'b1;
      tick();
      scl <= 1'b1;
      tick();
      sda_pull <= 1'b0;
      tick();
   endtask
   // Byte out, most significant bit first, then the slave's answer
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         sda_pull <= ~b[i];
         tick();
         pulse(s);
      end
      sda_pull <= 1'b0;
      tick();
      pulse(s);
      ack = ~s;
   endtask
   // Byte in, then acknowledge unless it is the last one
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic s;
      sda_pull <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         tick();
         pulse(d[i]);
      end
      sda_pull <= ~last;
      tick();
      pulse(s);
   endtask
   // Single register write
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic k1, k2, k3;
      start();
      send_byte({SLAVE_ADDR_W, 1'b0}, k1);
      send_byte(a, k2);
      send_byte(d, k3);
      stop();
      if ((k1 & k2 & k3) !== 1'b1) nacks++;
   endtask
   // Register read: pointer first, then repeated start and read address
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic k1, k2, k3;
      start();
      send_byte({SLAVE_ADDR_W, 1'b0}, k1);
      send_byte(a, k2);
      start();
      send_byte({SLAVE_ADDR_W, 1'b1}, k3);
      recv_byte(1'b1, d);
      stop();
      if ((k1 & k2 & k3) !== 1'b1) nacks++;
   endtask
   // Address byte alone, to see who answers
   task automatic probe(input logic [7:0] b, output logic ack);
      start();
      send_byte(b, ack);
      stop();
   endtask
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the charger register bank
// Assumes: Bus master model drives the pins; data line has a pull-up
// Notes: Short safety and blink counts keep the run brief
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb
   import charger_pkg::*;
;
   localparam int TIMER = 2000;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic role = 1'b0;
   logic step_up = 1'b0;
   logic fault_act = 1'b0;
   logic [1:0] chg_state = 2'h0;
   logic [2:0] fault = 3'h0;
   logic [7:0] mon = 8'h5c;
   logic [7:0] d;
   logic scl, host_pull, sda_oe, kick, expired, ind_oe, in_use, ack;
   wire sda_in = ~(sda_oe | host_pull);
   charge_ctrl_s ctrl;
   int n_errors = 0;
   int checked = 0;
   int n_kick = 0;
   // System clock and an unrelated link clock
   always #50 clk = ~clk;
   initial begin
      #7;
      forever #16 link_clk = ~link_clk;
   end
   charger_register_bank #(.SAFETY_TIMER_CYCLES(TIMER), .FAULT_BLINK_CYCLES(4)) uut (.clk(clk),
      .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
      .host_role_pin_level(role), .charge_state(chg_state), .step_up_active(step_up), .fault_code(fault),
      .fault_active(fault_act), .boost_fault(1'b0), .special_live(2'h0), .monitor_bits(mon), .ctrl(ctrl),
      .charge_current_in_use(in_use), .safety_timer_kick(kick), .safety_timer_expired(expired),
      .indicator_out(), .indicator_oe(ind_oe));
   i2c_host_model host (.clk(clk), .sda_in(sda_in), .scl(scl), .sda_pull(host_pull));
   // Count timer restarts
   always @(posedge clk) if (kick === 1'b1) n_kick <= n_kick + 1;
   task automatic t_defaults();
      logic [7:0] offs [6] = '{8'h01, 8'h02, 8'h04, 8'h03, 8'h07, 8'h10};
      logic [7:0] exps [6] = '{8'h70, 8'h0a, 8'h89, 8'h4d, 8'h00, 8'h5c};
      for (int i = 0; i < 6; i++) begin
         host.read_reg(offs[i], d);
         `CHK("reset value", exps[i], d)
      end
      host.read_reg(8'h00, d);
      `CHK("status reset bits", 2'b10, {d[6], d[3]})
   endtask
   task automatic t_status();
      @(posedge clk);
      role <= 1'b1;
      step_up <= 1'b1;
      fault <= 3'h5;
      chg_state <= 2'h2;
      host.write_reg(8'h00, 8'h4f);
      host.read_reg(8'h00, d);
      `CHK("status live", 8'hed, d)
      role <= 1'b0;
      step_up <= 1'b0;
      fault <= 3'h0;
      host.read_reg(8'h00, d);
      `CHK("status idle", 8'h60, d)
   endtask
   task automatic t_timer();
      int k, hi;
      host.write_reg(8'h01, 8'h74);
      k = n_kick;
      host.write_reg(8'h00, 8'h80);
      `CHK("kick count", k + 1, n_kick)
      `CHK("expired after kick", 1'b0, expired)
      repeat (TIMER) @(posedge clk);
      `CHK("expired while off", 1'b1, expired)
      chg_state <= 2'h1;
      host.write_reg(8'h00, 8'h00);
      `CHK("no kick on zero", k + 1, n_kick)
      `CHK("indicator held off", 1'b0, ind_oe)
      fault_act <= 1'b1;
      hi = 0;
      repeat (12) begin
         @(posedge clk);
         hi += (ind_oe === 1'b1);
      end
      `CHK("fault blink", 1'b1, hi > 0 && hi < 12)
      fault_act <= 1'b0;
      host.write_reg(8'h00, 8'h40);
      `CHK("indicator on charging", 1'b1, ind_oe)
   endtask
   task automatic t_config();
      logic [1:0] v;
      logic [7:0] w;
      for (int i = 0; i < 4; i++) begin
         v = i[1:0];
         w = {~v, v, v[0], 1'b0, v[1], v[0]};
         host.write_reg(8'h01, w);
         host.read_reg(8'h01, d);
         `CHK("config readback", w, d)
         `CHK("config applied", w, ctrl.cfg)
      end
   endtask
   task automatic t_soft_reset();
      host.write_reg(8'h06, 8'h33);
      host.write_reg(8'h05, 8'h04);
      `CHK("current code in use", 1'b1, in_use)
      host.write_reg(8'h04, 8'h52);
      host.read_reg(8'h04, d);
      `CHK("current cfg", 8'hda, d)
      host.write_reg(8'h02, 8'hff);
      `CHK("float written", 8'hff, ctrl.flt)
      host.write_reg(8'h04, 8'h80);
      `CHK("cfg default", 8'h70, ctrl.cfg)
      `CHK("float default", 8'h0a, ctrl.flt)
      `CHK("current default", 8'h89, ctrl.cur)
      `CHK("limits kept", 8'h33, ctrl.saf)
      `CHK("special default", 8'h24, ctrl.spc)
      `CHK("fixed select default", 1'b0, in_use)
   endtask
   task automatic t_refused();
      host.probe(8'hd6, ack);
      `CHK("foreign address", 1'b0, ack)
      host.write_reg(8'h07, 8'hff);
      host.read_reg(8'h01, d);
      `CHK("unmapped write", 8'h70, d)
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_defaults();
      t_status();
      t_timer();
      t_config();
      t_soft_reset();
      t_refused();
      `CHK("missed acks", 0, host.nacks)
      tally_and_finish();
   end
   // Watchdog against a hung bus
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end
endmodule
